// File: rtl/wsl_link_io.sv
/*
 * host pin side of the wireless serial link unit: serial port with flow control,
 * link status and disconnect lines, handshake emulation, voice gating, Avalon-MM
 * register slave with interrupt.
 * assumes the radio side is synchronous logic on clk; host pins are asynchronous.
 */
// Chosen here: register access over Avalon-MM and the address map.
// Overview of operation
// - tx and rts out, rx and cts in
// - disconnect line high closes and refuses links
// - link status pin follows connection state
// - handshake emulation role set by configuration
// - terminal role: ri/dcd/dsr in, dtr out
// - handshake levels carried apart from data
// - data and voice pass transparently when linked
// - default setup forwards data once linked
// - config bytes only while unlinked
// - one link, acting as master or slave
// - serial fixed at 38400 8N1 with flow
`timescale 1ns/1ps
module wsl_link_io #(
   parameter int BIT_CYC = wsl_pkg::BIT_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [4:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   output logic irq,
   // host serial pins
   input wire logic uartRxPin,
   output logic uartTxPin,
   output logic rtsNPin,
   input wire logic ctsNPin,
   // host general purpose lines
   input wire logic discReqPin,
   output logic linkUpPin,
   input wire wsl_pkg::wsl_hs_t hsIn,
   output wsl_pkg::wsl_hs_t hsOut,
   output wsl_pkg::wsl_hs_t hsOe,
   // radio side
   input wire logic radioUp,
   output logic radioAllow,
   output logic radioDrop,
   output logic radioMaster,
   output wsl_pkg::wsl_byte_s linkTx,
   input wire logic linkTxReady,
   input wire wsl_pkg::wsl_byte_s linkRx,
   output logic linkRxReady,
   input wire wsl_pkg::wsl_hs_t peerHs,
   output wsl_pkg::wsl_hs_t hsToPeer,
   // voice channel
   input wire wsl_pkg::wsl_voice_s voiceIn,
   output wsl_pkg::wsl_voice_s voiceToLink,
   input wire wsl_pkg::wsl_voice_s voiceFromLink,
   output wsl_pkg::wsl_voice_s voiceOut
);
   import wsl_pkg::*;

   localparam int NS = 7;

   logic [NS-1:0] pinRaw;
   logic [NS-1:0] sync1_q;
   logic [NS-1:0] sync2_q;
   logic rxS;
   logic ctsNS;
   logic discS;
   wsl_hs_t hsS;

   wsl_link_e lnk_q;
   logic [1:0] ctrl_q;
   logic [IRQ_W-1:0] irqStat_q;
   logic [IRQ_W-1:0] irqMask_q;
   logic [IRQ_W-1:0] irqEv;
   logic [7:0] cfgRx_q;
   logic cfgFull_q;
   logic txPend_q;
   logic [7:0] txByte_q;
   logic txStart_q;
   logic txBusy;
   logic txLine;
   logic rxValid;
   logic [7:0] rxData;
   logic rxFrameErr;
   logic frameErr_q;
   wsl_hs_t hsOeNext;
   logic wrAcc;
   logic rdAcc;
   logic rxAccept;
   logic cfgTxWr;
   logic cfgPop;

   // every host pin passes two flops; only the second stage is read
   assign pinRaw = {hsIn, discReqPin, ctsNPin, uartRxPin};
   generate
      for (genvar i = 0; i < NS; i++) begin : g_sync
         always_ff @(posedge clk) begin
            if (rst) begin
               sync1_q[i] <= (i == 0 || i == 1) ? 1'b1 : 1'b0;
               sync2_q[i] <= (i == 0 || i == 1) ? 1'b1 : 1'b0;
            end else begin
               sync1_q[i] <= pinRaw[i];
               sync2_q[i] <= sync1_q[i];
            end
         end
      end
   endgenerate
   assign rxS = sync2_q[0];
   assign ctsNS = sync2_q[1];
   assign discS = sync2_q[2];
   assign hsS = sync2_q[6:3];

   // bus handshake: one wait cycle, then a single accept cycle
   assign wrAcc = avsWrite && !avsWaitRequest;
   assign rdAcc = avsRead && !avsWaitRequest;
   assign cfgTxWr = wrAcc && avsAddress == REG_CFG_TX;
   assign cfgPop = rdAcc && avsAddress == REG_CFG_RX;
   assign rxAccept = linkRx.valid && linkRxReady;

   always_ff @(posedge clk) begin
      if (rst) begin
         avsWaitRequest <= 1'b1;
      end else begin
         avsWaitRequest <= !((avsRead || avsWrite) && avsWaitRequest);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         avsReadData <= 32'h0000_0000;
      end else if ((avsRead || avsWrite) && avsWaitRequest) begin
         unique case (avsAddress)
            REG_CTRL: avsReadData <= {30'h0, ctrl_q};
            REG_STATUS: avsReadData <= {27'h0, frameErr_q, txPend_q, cfgFull_q, discS,
                                        lnk_q == LNK_ON};
            REG_IRQ_STAT: avsReadData <= {29'h0, irqStat_q};
            REG_IRQ_MASK: avsReadData <= {29'h0, irqMask_q};
            REG_CFG_RX: avsReadData <= {23'h0, cfgFull_q, cfgRx_q};
            REG_HS_LOCAL: avsReadData <= {28'h0, hsS};
            default: avsReadData <= 32'h0000_0000;
         endcase
      end
   end

   // role and master/slave selection; reset value is the ready-to-run default
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= CTRL_RST;
      end else if (wrAcc && avsAddress == REG_CTRL) begin
         ctrl_q <= avsWriteData[1:0];
      end
   end

   // a single link at a time; disconnect request moves LNK_ON to the drop state unless radioUp falls first
   always_ff @(posedge clk) begin
      if (rst) begin
         lnk_q <= LNK_CFG;
      end else begin
         unique case (lnk_q)
            LNK_CFG: if (radioUp && !discS) lnk_q <= LNK_ON;
            LNK_ON: begin
               if (!radioUp) begin
                  lnk_q <= LNK_CFG;
               end else if (discS) begin
                  lnk_q <= LNK_DROP;
               end
            end
            LNK_DROP: if (!radioUp) lnk_q <= LNK_CFG;
            default: lnk_q <= LNK_CFG;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         radioAllow <= 1'b0;
         radioDrop <= 1'b0;
         radioMaster <= 1'b0;
         linkUpPin <= 1'b0;
      end else begin
         radioAllow <= !discS;
         radioDrop <= discS && radioUp;
         radioMaster <= ctrl_q[CTRL_MASTER];
         linkUpPin <= radioUp;
      end
   end

   // enables taken from the role itself, so levels never lag a role change
   assign hsOeNext = ctrl_q[CTRL_DCE] ? HS_OE_DCE : HS_OE_DTE;

   // handshake emulation: direction set by role, levels sent apart from data
   always_ff @(posedge clk) begin
      if (rst) begin
         hsOe <= HS_OE_DTE;
         hsOut <= 4'h0;
         hsToPeer <= 4'h0;
      end else begin
         hsOe <= hsOeNext;
         hsOut <= (lnk_q == LNK_ON) ? (peerHs & hsOeNext) : 4'h0;
         hsToPeer <= hsS & ~hsOeNext;
      end
   end

   wsl_uart #(
      .BIT_CYC(BIT_CYC)
   ) u_uart (
      .clk(clk),
      .rst(rst),
      .txStart(txStart_q),
      .txData(txByte_q),
      .txBusy(txBusy),
      .txLine(txLine),
      .rxLine(rxS),
      .rxValid(rxValid),
      .rxData(rxData),
      .rxFrameErr(rxFrameErr)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         uartTxPin <= 1'b1;
         frameErr_q <= 1'b0;
      end else begin
         uartTxPin <= txLine;
         frameErr_q <= rxFrameErr;
      end
   end

   // serial received bytes: to the link when linked, to the command register in LNK_CFG, dropped in LNK_DROP
   always_ff @(posedge clk) begin
      if (rst) begin
         linkTx <= '0;
      end else if (rxValid && lnk_q == LNK_ON && !linkTx.valid) begin
         linkTx <= '{valid: 1'b1, data: rxData};
      end else if (linkTxReady || lnk_q != LNK_ON) begin
         linkTx.valid <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cfgRx_q <= 8'h00;
         cfgFull_q <= 1'b0;
      end else if (rxValid && lnk_q == LNK_CFG && !cfgFull_q) begin
         cfgRx_q <= rxData;
         cfgFull_q <= 1'b1;
      end else if (cfgPop) begin
         cfgFull_q <= 1'b0;
      end
   end

   // host is told to pause while the next byte would have nowhere to go
   always_ff @(posedge clk) begin
      if (rst) begin
         rtsNPin <= 1'b1;
      end else begin
         rtsNPin <= (lnk_q == LNK_ON) ? linkTx.valid :
                    (lnk_q == LNK_CFG) ? cfgFull_q : 1'b1;
      end
   end

   // bytes toward the host: link data when linked, command replies in LNK_CFG, none in LNK_DROP
   always_ff @(posedge clk) begin
      if (rst) begin
         linkRxReady <= 1'b0;
      end else begin
         linkRxReady <= lnk_q == LNK_ON && !txPend_q && !txBusy && !rxAccept;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         txPend_q <= 1'b0;
         txByte_q <= 8'h00;
         txStart_q <= 1'b0;
      end else begin
         txStart_q <= 1'b0;
         if (rxAccept) begin
            txPend_q <= 1'b1;
            txByte_q <= linkRx.data;
         end else if (cfgTxWr && !txPend_q && lnk_q == LNK_CFG) begin
            txPend_q <= 1'b1;
            txByte_q <= avsWriteData[7:0];
         end else if (txPend_q && !txBusy && !txStart_q && !ctsNS) begin
            txPend_q <= 1'b0;
            txStart_q <= 1'b1;
         end
      end
   end

   // voice frames pass only while linked, in both directions independently
   always_ff @(posedge clk) begin
      if (rst) begin
         voiceToLink <= '0;
         voiceOut <= '0;
      end else begin
         voiceToLink <= '{valid: voiceIn.valid && lnk_q == LNK_ON,
                          sample: voiceIn.sample};
         voiceOut <= '{valid: voiceFromLink.valid && lnk_q == LNK_ON,
                       sample: voiceFromLink.sample};
      end
   end

   // sticky events, write one to clear; a new event wins over its clear
   assign irqEv[IRQ_UP] = lnk_q == LNK_CFG && radioUp && !discS;
   assign irqEv[IRQ_DOWN] = lnk_q != LNK_CFG && !radioUp;
   assign irqEv[IRQ_CFG] = rxValid && lnk_q == LNK_CFG && !cfgFull_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         irqStat_q <= IRQ_RST;
      end else if (wrAcc && avsAddress == REG_IRQ_STAT) begin
         irqStat_q <= (irqStat_q & ~avsWriteData[IRQ_W-1:0]) | irqEv;
      end else begin
         irqStat_q <= irqStat_q | irqEv;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irqMask_q <= IRQ_RST;
      end else if (wrAcc && avsAddress == REG_IRQ_MASK) begin
         irqMask_q <= avsWriteData[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStat_q & irqMask_q);
      end
   end

   property p_discRefuse;
      @(posedge clk) disable iff (rst) discReqPin [*3] |=> !radioAllow;
   endproperty
   a_discRefuse: assert property (p_discRefuse)
      else $error("disconnect request did not refuse links");

   property p_discDrop;
      @(posedge clk) disable iff (rst)
         (discReqPin && radioUp) [*4] |-> radioDrop && lnk_q != LNK_ON;
   endproperty
   a_discDrop: assert property (p_discDrop)
      else $error("link not closed under disconnect request");

   property p_linkPin;
      @(posedge clk) disable iff (rst) $rose(radioUp) |=> linkUpPin [*1] ##1 1;
   endproperty
   a_linkPin: assert property (p_linkPin)
      else $error("link status pin late");

   property p_linkLow;
      @(posedge clk) disable iff (rst) !radioUp [*2] |-> !linkUpPin;
   endproperty
   a_linkLow: assert property (p_linkLow)
      else $error("link status high without connection");

   property p_ctsGate;
      @(posedge clk) disable iff (rst) txStart_q |-> $past(!ctsNS);
   endproperty
   a_ctsGate: assert property (p_ctsGate)
      else $error("transmit started while host not clear");

   property p_hsDir;
      @(posedge clk) disable iff (rst)
         ctrl_q[CTRL_DCE] [*2] |-> hsOe == HS_OE_DCE && (hsOut & ~hsOe) == 4'h0;
   endproperty
   a_hsDir: assert property (p_hsDir)
      else $error("handshake directions wrong for role");

   property p_cfgOnly;
      @(posedge clk) disable iff (rst) $rose(cfgFull_q) |-> $past(lnk_q) == LNK_CFG;
   endproperty
   a_cfgOnly: assert property (p_cfgOnly)
      else $error("command byte taken while linked");

   property p_voiceGate;
      @(posedge clk) disable iff (rst)
         voiceToLink.valid |-> $past(voiceIn.valid) && $past(lnk_q) == LNK_ON;
   endproperty
   a_voiceGate: assert property (p_voiceGate)
      else $error("voice forwarded without link");

   property p_irqLevel;
      @(posedge clk) disable iff (rst) (|(irqStat_q & irqMask_q)) [*2] |-> irq;
   endproperty
   a_irqLevel: assert property (p_irqLevel)
      else $error("interrupt not raised for pending event");
endmodule : wsl_link_io

// File: common/wsl_pkg.sv
/*
 * shared constants, types and register map of the wireless serial link pin block.
 * assumes a 20 MHz system clock and one synchronous active-high reset.
 */
package wsl_pkg;
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int BAUD = 38400;
   localparam int BIT_CYC = CLK_HZ / BAUD;
   localparam int HALF_CYC = BIT_CYC / 2;
   localparam int DATA_BITS = 8;

   // register byte offsets
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h04;
   localparam logic [4:0] REG_IRQ_STAT = 5'h08;
   localparam logic [4:0] REG_IRQ_MASK = 5'h0c;
   localparam logic [4:0] REG_CFG_RX = 5'h10;
   localparam logic [4:0] REG_CFG_TX = 5'h14;
   localparam logic [4:0] REG_HS_LOCAL = 5'h18;

   // control fields
   localparam int CTRL_DCE = 0;
   localparam int CTRL_MASTER = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;

   // status fields
   localparam int ST_LINKED = 0;
   localparam int ST_DISC = 1;
   localparam int ST_CFG_FULL = 2;
   localparam int ST_TX_PEND = 3;
   localparam int ST_FRAME_ERR = 4;

   // interrupt fields
   localparam int IRQ_W = 3;
   localparam int IRQ_UP = 0;
   localparam int IRQ_DOWN = 1;
   localparam int IRQ_CFG = 2;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

   // handshake line bits: ring, terminal ready, carrier, set ready
   localparam int HS_RI = 0;
   localparam int HS_DTR = 1;
   localparam int HS_DCD = 2;
   localparam int HS_DSR = 3;
   localparam logic [3:0] HS_OE_DTE = 4'h2;
   localparam logic [3:0] HS_OE_DCE = 4'hd;

   typedef logic [3:0] wsl_hs_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } wsl_byte_s;

   typedef struct packed {
      logic valid;
      logic [15:0] sample;
   } wsl_voice_s;

   typedef enum logic [1:0] {
      LNK_CFG = 2'b00,
      LNK_ON = 2'b01,
      LNK_DROP = 2'b10
   } wsl_link_e;
endpackage : wsl_pkg

// File: rtl/wsl_uart.sv
/*
 * fixed-format 8N1 serial transmitter and receiver.
 * assumes the receive input is already synchronised to clk.
 */
`timescale 1ns/1ps
module wsl_uart #(
   parameter int BIT_CYC = wsl_pkg::BIT_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // transmit side
   input wire logic txStart,
   input wire logic [7:0] txData,
   output logic txBusy,
   output logic txLine,
   // receive side
   input wire logic rxLine,
   output logic rxValid,
   output logic [7:0] rxData,
   output logic rxFrameErr
);
   import wsl_pkg::*;

   localparam int CW = $clog2(BIT_CYC + 1);
   localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);
   localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2);

   logic [CW-1:0] txCnt_q;
   logic [3:0] txBit_q;
   logic [9:0] txSh_q;
   logic [CW-1:0] rxCnt_q;
   logic [3:0] rxBit_q;
   logic [8:0] rxSh_q;
   logic rxAct_q;

   assign txLine = txSh_q[0];

   always_ff @(posedge clk) begin
      if (rst) begin
         txSh_q <= 10'h3ff;
         txBusy <= 1'b0;
         txCnt_q <= '0;
         txBit_q <= 4'h0;
      end else if (!txBusy) begin
         if (txStart) begin
            txSh_q <= {1'b1, txData, 1'b0};
            txBusy <= 1'b1;
            txCnt_q <= FULL;
            txBit_q <= 4'h9;
         end
      end else if (txCnt_q != '0) begin
         txCnt_q <= txCnt_q - 1'b1;
      end else if (txBit_q == 4'h0) begin
         txBusy <= 1'b0;
      end else begin
         txSh_q <= {1'b1, txSh_q[9:1]};
         txBit_q <= txBit_q - 1'b1;
         txCnt_q <= FULL;
      end
   end

   // sample each bit mid-cell; start edge restarts the cell count
   always_ff @(posedge clk) begin
      if (rst) begin
         rxAct_q <= 1'b0;
         rxCnt_q <= '0;
         rxBit_q <= 4'h0;
         rxSh_q <= 9'h000;
         rxValid <= 1'b0;
         rxData <= 8'h00;
         rxFrameErr <= 1'b0;
      end else begin
         rxValid <= 1'b0;
         if (!rxAct_q) begin
            if (!rxLine) begin
               rxAct_q <= 1'b1;
               rxCnt_q <= HALF;
               rxBit_q <= 4'h0;
            end
         end else if (rxCnt_q != '0) begin
            rxCnt_q <= rxCnt_q - 1'b1;
         end else if (rxBit_q == 4'h0 && rxLine) begin
            rxAct_q <= 1'b0;
         end else if (rxBit_q == 4'h9) begin
            rxAct_q <= 1'b0;
            rxValid <= rxLine;
            rxData <= rxSh_q[8:1];
            rxFrameErr <= !rxLine;
         end else begin
            rxSh_q <= {rxLine, rxSh_q[8:1]};
            rxBit_q <= rxBit_q + 1'b1;
            rxCnt_q <= FULL;
         end
      end
   end
endmodule : wsl_uart

// File: bench/wsl_host_model.sv
/*
 * host serial port model: sends 8N1 frames into the unit and decodes its frames.
 * assumes clk is the unit clock and BIT_CYC matches the unit instance.
 */
`timescale 1ns/1ps
module wsl_host_model #(
   parameter int BIT_CYC = 16
) (
   // clock
   input wire logic clk,
   // serial pins seen from the host
   input wire logic uartTxPin,
   input wire logic rtsNPin,
   output logic uartRxPin,
   output logic ctsNPin
);
   logic holdOff = 1'b0;
   logic [7:0] shiftQ = 8'h00;
   logic [7:0] gotByte = 8'h00;
   int gotCount = 0;
   int stallCount = 0;
   int bitN = 0;
   int cnt = 0;
   initial uartRxPin = 1'b1;
   assign ctsNPin = holdOff;
   // a frame is started once the unit shows rts low, or anyway after 5000 cycles of waiting
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] fr;
      int i;
      fr = {1'b1, b, 1'b0};
      for (i = 0; i < 5000 && rtsNPin !== 1'b0; i++) @(posedge clk);
      if (rtsNPin !== 1'b0) stallCount++;
      for (i = 0; i < 10; i++) begin
         uartRxPin <= fr[i];
         repeat (BIT_CYC) @(posedge clk);
      end
   endtask : send_byte
   // samples each cell in its middle, lsb first
   always @(posedge clk) begin
      if (bitN == 0) begin
         if (uartTxPin === 1'b0) begin
            bitN <= 1;
            cnt <= BIT_CYC + BIT_CYC / 2 - 1;
         end
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end else if (bitN < 9) begin
         shiftQ <= {uartTxPin, shiftQ[7:1]};
         bitN <= bitN + 1;
         cnt <= BIT_CYC - 1;
      end else begin
         gotByte <= shiftQ;
         gotCount <= gotCount + 1;
         bitN <= 0;
      end
   end
endmodule : wsl_host_model

// File: bench/tb_top.sv
/*
 * self-checking bench for the wireless serial link pin block.
 * assumes a host serial model on the pins and drives the radio side itself.
 */
`timescale 1ns/1ps
module tb_top;
   import wsl_pkg::*;
   localparam int TB_BIT = 16;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] avsAddress = 5'h00;
   logic avsRead = 1'b0;
   logic avsWrite = 1'b0;
   logic [31:0] avsWriteData = 32'h0000_0000;
   logic [31:0] avsReadData;
   logic avsWaitRequest, irq, uartRxPin, uartTxPin, rtsNPin, ctsNPin;
   logic discReqPin = 1'b0;
   logic linkUpPin, radioAllow, radioDrop, radioMaster, linkRxReady;
   logic radioUp = 1'b0;
   logic linkTxReady = 1'b0;
   wsl_hs_t hsIn = 4'h0;
   wsl_hs_t peerHs = 4'h0;
   wsl_hs_t hsOut, hsOe, hsToPeer;
   wsl_byte_s linkTx;
   wsl_byte_s linkRx = 9'h000;
   wsl_voice_s voiceIn = 17'h0_0000;
   wsl_voice_s voiceFromLink = 17'h0_0000;
   wsl_voice_s voiceToLink, voiceOut;
   int badCount = 0;
   int cmpCount = 0;
   logic [31:0] rdq;

   initial begin
      forever #25 clk = ~clk;
   end

   wsl_link_io #(.BIT_CYC(TB_BIT)) wsl_link_io_i (.clk(clk), .rst(rst),
      .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
      .avsWriteData(avsWriteData), .avsReadData(avsReadData),
      .avsWaitRequest(avsWaitRequest), .irq(irq), .uartRxPin(uartRxPin),
      .uartTxPin(uartTxPin), .rtsNPin(rtsNPin), .ctsNPin(ctsNPin),
      .discReqPin(discReqPin), .linkUpPin(linkUpPin), .hsIn(hsIn), .hsOut(hsOut),
      .hsOe(hsOe), .radioUp(radioUp), .radioAllow(radioAllow), .radioDrop(radioDrop),
      .radioMaster(radioMaster), .linkTx(linkTx), .linkTxReady(linkTxReady),
      .linkRx(linkRx), .linkRxReady(linkRxReady), .peerHs(peerHs), .hsToPeer(hsToPeer),
      .voiceIn(voiceIn), .voiceToLink(voiceToLink), .voiceFromLink(voiceFromLink),
      .voiceOut(voiceOut));

   wsl_host_model #(.BIT_CYC(TB_BIT)) wsl_host_model_i (.clk(clk),
      .uartTxPin(uartTxPin), .rtsNPin(rtsNPin), .uartRxPin(uartRxPin),
      .ctsNPin(ctsNPin));

   task automatic finish_test();
      if (badCount == 0 && cmpCount > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         badCount++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // request held until waitrequest is sampled low; data taken at that edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int i;
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= ~wr;
      avsWriteData <= d;
      @(posedge clk);
      for (i = 0; i < 50 && avsWaitRequest !== 1'b0; i++) @(posedge clk);
      if (i == 50) begin
         badCount++;
         finish_test();
      end
      rdq = avsReadData;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic rd_chk(input string name, input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(name, rdq, exp);
   endtask : rd_chk

   task automatic t_reset();
      repeat (3) @(posedge clk);
      chk("hsOe", {28'h0, hsOe}, {28'h0, HS_OE_DTE});
      chk("linkUp", {31'h0, linkUpPin}, 32'h0000_0000);
      chk("txIdle", {31'h0, uartTxPin}, 32'h0000_0001);
      chk("allow", {31'h0, radioAllow}, 32'h0000_0001);
      rd_chk("ctrl", REG_CTRL, 32'h0000_0000);
      rd_chk("unmapped", 5'h1c, 32'h0000_0000);
   endtask : t_reset

   // unlinked host bytes land in the command register and raise an event
   task automatic t_config();
      wsl_host_model_i.send_byte(8'hA5);
      repeat (4) @(posedge clk);
      chk("rtsCfgFull", {31'h0, rtsNPin}, 32'h0000_0001);
      rd_chk("cfgRx", REG_CFG_RX, 32'h0000_01A5);
      rd_chk("irqStat", REG_IRQ_STAT, 32'h0000_0004);
      bus(1'b1, REG_IRQ_MASK, 32'h0000_0004);
      repeat (2) @(posedge clk);
      chk("irqHigh", {31'h0, irq}, 32'h0000_0001);
      bus(1'b1, REG_IRQ_STAT, 32'h0000_0004);
      repeat (2) @(posedge clk);
      chk("irqLow", {31'h0, irq}, 32'h0000_0000);
   endtask : t_config

   // reply byte to the host must wait while the host holds cts high
   task automatic t_cfgtx();
      int i;
      int n0;
      n0 = wsl_host_model_i.gotCount;
      wsl_host_model_i.holdOff <= 1'b1;
      bus(1'b1, REG_CFG_TX, 32'h0000_003C);
      repeat (3 * TB_BIT) @(posedge clk);
      chk("ctsHold", wsl_host_model_i.gotCount, n0);
      wsl_host_model_i.holdOff <= 1'b0;
      for (i = 0; i < 400 && wsl_host_model_i.gotCount == n0; i++) @(posedge clk);
      chk("cfgTxByte", {24'h0, wsl_host_model_i.gotByte}, 32'h0000_003C);
   endtask : t_cfgtx

   task automatic t_link();
      int i;
      int n0;
      radioUp <= 1'b1;
      for (i = 0; i < 4 && linkUpPin !== 1'b1; i++) @(posedge clk);
      chk("linkUpHi", {31'h0, linkUpPin}, 32'h0000_0001);
      wsl_host_model_i.send_byte(8'h5A);
      for (i = 0; i < 100 && linkTx.valid !== 1'b1; i++) @(posedge clk);
      chk("linkTx", {23'h0, linkTx}, 32'h0000_015A);
      chk("rtsLinkFull", {31'h0, rtsNPin}, 32'h0000_0001);
      linkTxReady <= 1'b1;
      @(posedge clk);
      linkTxReady <= 1'b0;
      rd_chk("cfgRxEmpty", REG_CFG_RX, 32'h0000_00A5);
      n0 = wsl_host_model_i.gotCount;
      linkRx <= '{valid: 1'b1, data: 8'h96};
      @(posedge clk);
      for (i = 0; i < 400 && linkRxReady !== 1'b1; i++) @(posedge clk);
      linkRx <= 9'h000;
      for (i = 0; i < 400 && wsl_host_model_i.gotCount == n0; i++) @(posedge clk);
      chk("linkRxByte", {24'h0, wsl_host_model_i.gotByte}, 32'h0000_0096);
      chk("rtsWait", wsl_host_model_i.stallCount, 32'h0000_0000);
   endtask : t_link

   // line levels travel apart from data, directions follow the role
   task automatic t_hs();
      peerHs <= 4'hF;
      hsIn <= 4'hD;
      voiceIn <= '{valid: 1'b1, sample: 16'h1234};
      voiceFromLink <= '{valid: 1'b1, sample: 16'hBEEF};
      repeat (6) @(posedge clk);
      chk("hsOutDte", {28'h0, hsOut}, 32'h0000_0002);
      chk("hsToPeerDte", {28'h0, hsToPeer}, 32'h0000_000D);
      chk("voiceTx", {15'h0, voiceToLink}, 32'h0001_1234);
      chk("voiceRx", {15'h0, voiceOut}, 32'h0001_BEEF);
      bus(1'b1, REG_CTRL, 32'h0000_0003);
      hsIn <= 4'h2;
      repeat (6) @(posedge clk);
      chk("hsOeDce", {28'h0, hsOe}, {28'h0, HS_OE_DCE});
      chk("hsOutDce", {28'h0, hsOut}, 32'h0000_000D);
      chk("hsToPeerDce", {28'h0, hsToPeer}, 32'h0000_0002);
      rd_chk("hsLocal", REG_HS_LOCAL, 32'h0000_0002);
      chk("master", {31'h0, radioMaster}, 32'h0000_0001);
      bus(1'b1, REG_CTRL, 32'h0000_0000);
      repeat (3) @(posedge clk);
      chk("slave", {31'h0, radioMaster}, 32'h0000_0000);
   endtask : t_hs

   task automatic t_disc();
      int i;
      discReqPin <= 1'b1;
      for (i = 0; i < 10 && radioDrop !== 1'b1; i++) @(posedge clk);
      chk("drop", {31'h0, radioDrop}, 32'h0000_0001);
      chk("refuse", {31'h0, radioAllow}, 32'h0000_0000);
      radioUp <= 1'b0;
      repeat (3) @(posedge clk);
      chk("linkUpLo", {31'h0, linkUpPin}, 32'h0000_0000);
      chk("voiceOff", {31'h0, voiceToLink.valid}, 32'h0000_0000);
      rd_chk("irqUpDown", REG_IRQ_STAT, 32'h0000_0003);
      rd_chk("status", REG_STATUS, 32'h0000_0002);
      radioUp <= 1'b1;
      repeat (4) @(posedge clk);
      chk("stillRefuse", {31'h0, radioAllow}, 32'h0000_0000);
      chk("hsOutOff", {28'h0, hsOut}, 32'h0000_0000);
      radioUp <= 1'b0;
      discReqPin <= 1'b0;
      for (i = 0; i < 10 && radioAllow !== 1'b1; i++) @(posedge clk);
      chk("allowAgain", {31'h0, radioAllow}, 32'h0000_0001);
   endtask : t_disc

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_config();
      t_cfgtx();
      t_link();
      t_hs();
      t_disc();
      finish_test();
   end

   // hang guard
   initial begin
      repeat (90000) @(posedge clk);
      badCount++;
      finish_test();
   end
endmodule : tb_top
